//--- design/tbc_dev.sv
// Our own choices: the AXI4-Lite register port and the register offsets.
`timescale 1ns/10ps
// Summary of operation
// - Entry maps only when valid flag set.
// - User stores need writable flag set.
// - Load tag copies register into staging.
// - Store tag returns tag staging value.
// - Row index combines row and process.
// - Set i chosen when select bit i.
// - Tag read needs exactly one select.
// - Tag write fills every selected set.
// - Data staging: page number upper half.
// - Load data copies register into staging.
// - Store data returns data staging value.
// - Data read needs exactly one select.
// - Data write fills every selected set.
// - Control word write-only, kernel only.
// - Control word load has no side effect.
// - Launch operand comes from aligned word.
// - Exactly one operation bit before launch.
// - Peripheral read sends operand as address.
// - Peripheral write sends operand as address.
// - Control set uses previously latched register.
// - User-mode privileged commands raise fault.
module tbc_dev #(
   parameter int ROW_BITS = tbc_pkg::ROW_W
) (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Command link from the processor end.
   tbc_if.dev lnk,
   // Translation lookup request.
   input wire logic lk_valid,
   input wire logic [31:0] lk_vaddr,
   input wire logic [7:0] lk_pid,
   input wire logic lk_store,
   input wire logic lk_user,
   // Translation lookup answer.
   output logic lk_done,
   output logic lk_hit,
   output logic [15:0] lk_ppn,
   output logic lk_wp_fault,
   // Memory controller request.
   output logic mc_valid,
   output logic [2:0] mc_kind,
   output logic [31:0] mc_word,
   output logic [7:0] mc_reg
);
   import tbc_pkg::*;

   localparam int ROWS = 1 << ROW_BITS;

   // Row index from virtual address and process number.
   function automatic logic [ROW_BITS-1:0] row_index(input logic [31:0] va,
                                                     input logic [7:0] pid);
      row_index = va[VA_ROW_LSB +: ROW_BITS] ^ pid[ROW_BITS-1:0];
   endfunction

   // Entry storage holds no reset: software initialises it after power-up.
   logic [31:0] tag_mem [ROWS][SET_N];
   logic [PPN_W-1:0] ppn_mem [ROWS][SET_N];
   logic [31:0] tag_stg_r;             // Tag staging register.
   logic [31:0] dat_stg_r;             // Data staging register.
   logic [31:0] ctl_r;                 // Peripheral control word.
   logic [MCREG_W-1:0] mcreg_prev_r;   // Register number at the previous launch or control read.
   logic rsp_valid_r;
   logic rsp_fault_r;
   logic [31:0] rsp_data_r;
   logic lk_done_r, lk_hit_r, lk_wp_r;
   logic [15:0] lk_ppn_r;
   logic mc_valid_r;
   logic [2:0] mc_kind_r;
   logic [31:0] mc_word_r;
   logic [7:0] mc_reg_r;
   logic exec;                         // Command runs this cycle.
   logic priv_fault;                   // Command refused this cycle.
   logic [ROW_BITS-1:0] idx;           // Row addressed by the command.
   logic [SET_N-1:0] sel;              // Set selects of the command.
   logic [31:0] rd_tag;                // Tag of the selected set.
   logic [PPN_W-1:0] rd_ppn;           // Page number of the selected set.
   logic [ROW_BITS-1:0] lk_idx;
   logic lk_match;
   logic lk_wr;
   logic [PPN_W-1:0] lk_ppn_c;

   // Every command here is privileged, so user mode never executes one.
   // Refuse user mode.
   assign exec = lnk.cmd_valid && lnk.cmd_kernel;
   assign priv_fault = lnk.cmd_valid && !lnk.cmd_kernel;
   assign idx = row_index(lnk.cmd_addr, lnk.cmd_pid);
   assign sel = lnk.cmd_addr[VA_SEL_LSB +: SET_N];
   assign lk_idx = row_index(lk_vaddr, lk_pid);

   // Read mux ORs the selected sets; with one select it is that set alone.
   always_comb begin
      rd_tag = '0;
      rd_ppn = '0;
      for (int i = 0; i < SET_N; i++) begin
         if (sel[i]) begin
            rd_tag = rd_tag | tag_mem[idx][i];
            rd_ppn = rd_ppn | ppn_mem[idx][i];
         end
      end
   end

   // Lookup compares process and high page in every set of the row.
   always_comb begin
      lk_match = 1'b0;
      lk_wr = 1'b0;
      lk_ppn_c = '0;
      for (int i = 0; i < SET_N; i++) begin
         if (tag_mem[lk_idx][i][TAG_VALID_BIT] &&
             tag_mem[lk_idx][i][TAG_PID_LSB +: PID_W] == lk_pid &&
             tag_mem[lk_idx][i][TAG_HPG_LSB +: HPG_W] == lk_vaddr[VA_HPG_LSB +: HPG_W]) begin
            lk_match = 1'b1;
            lk_wr = tag_mem[lk_idx][i][TAG_WR_BIT];
            lk_ppn_c = ppn_mem[lk_idx][i];
         end
      end
   end

   // Tag staging register.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tag_stg_r <= STG_RST;
      end else if (exec && lnk.cmd_op == OP_LOAD_TAG) begin
         tag_stg_r <= lnk.cmd_data;
      end else if (exec && lnk.cmd_op == OP_TAG_READ) begin
         tag_stg_r <= rd_tag;
      end
   end

   // Data staging register; the lower half is left as loaded or zero.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dat_stg_r <= STG_RST;
      end else if (exec && lnk.cmd_op == OP_LOAD_DATA) begin
         dat_stg_r <= lnk.cmd_data;
      end else if (exec && lnk.cmd_op == OP_DATA_READ) begin
         dat_stg_r <= {rd_ppn, 16'h0000};
      end
   end

   // Entry writes go to every selected set so a row clears in one command.
   always_ff @(posedge aclk) begin
      for (int i = 0; i < SET_N; i++) begin
         if (exec && lnk.cmd_op == OP_TAG_WRITE && sel[i]) begin
            tag_mem[idx][i] <= tag_stg_r & TAG_MASK;
         end
         if (exec && lnk.cmd_op == OP_DATA_WRITE && sel[i]) begin
            ppn_mem[idx][i] <= dat_stg_r[DAT_PPN_LSB +: PPN_W];
         end
      end
   end

   // Control word has no read path at all; loading it starts nothing.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctl_r <= STG_RST;
      end else if (exec && lnk.cmd_op == OP_LOAD_CTL) begin
         ctl_r <= lnk.cmd_data;
      end
   end

   // Register number is captured at launch or control read so the next control set uses it.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mcreg_prev_r <= '0;
      end else if (exec && (lnk.cmd_op == OP_LAUNCH || lnk.cmd_op == OP_CTL_READ)) begin
         mcreg_prev_r <= ctl_r[CW_REG_LSB +: MCREG_W];
      end
   end

   // Memory controller request, one cycle per launch.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mc_valid_r <= 1'b0;
         mc_kind_r <= '0;
         mc_word_r <= '0;
         mc_reg_r <= '0;
      end else begin
         mc_valid_r <= exec && lnk.cmd_op == OP_LAUNCH;
         if (exec && lnk.cmd_op == OP_LAUNCH) begin
            mc_kind_r <= ctl_r[CW_SETCTL_BIT +: CW_KIND_W];
            mc_word_r <= lnk.cmd_data;
            mc_reg_r <= mcreg_prev_r;
         end
      end
   end

   // Answer to every command one cycle after it.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rsp_valid_r <= 1'b0;
         rsp_fault_r <= 1'b0;
         rsp_data_r <= '0;
      end else begin
         rsp_valid_r <= lnk.cmd_valid;
         rsp_fault_r <= priv_fault;
         if (exec && lnk.cmd_op == OP_STORE_TAG) begin
            rsp_data_r <= tag_stg_r;
         end else if (exec && lnk.cmd_op == OP_STORE_DATA) begin
            rsp_data_r <= dat_stg_r;
         end else begin
            rsp_data_r <= '0;
         end
      end
   end

   // Lookup answer one cycle after the request.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         lk_done_r <= 1'b0;
         lk_hit_r <= 1'b0;
         lk_wp_r <= 1'b0;
         lk_ppn_r <= '0;
      end else begin
         lk_done_r <= lk_valid;
         lk_hit_r <= lk_valid && lk_match;
         lk_wp_r <= lk_valid && lk_match && lk_store && lk_user && !lk_wr;
         lk_ppn_r <= lk_match ? lk_ppn_c : '0;
      end
   end

   assign lnk.rsp_valid = rsp_valid_r;
   assign lnk.rsp_fault = rsp_fault_r;
   assign lnk.rsp_data = rsp_data_r;
   assign lk_done = lk_done_r;
   assign lk_hit = lk_hit_r;
   assign lk_ppn = lk_ppn_r;
   assign lk_wp_fault = lk_wp_r;
   assign mc_valid = mc_valid_r;
   assign mc_kind = mc_kind_r;
   assign mc_word = mc_word_r;
   assign mc_reg = mc_reg_r;
endmodule

//--- design/tbc_host.sv
`timescale 1ns/10ps
// Processor end: software drives commands through AXI4-Lite registers.
module tbc_host (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address and data.
   input wire logic awvalid,
   output logic awready,
   input wire logic [4:0] awaddr,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   // AXI4-Lite write response.
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   // AXI4-Lite read.
   input wire logic arvalid,
   output logic arready,
   input wire logic [4:0] araddr,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   // Command link to the translation buffer end.
   tbc_if.host lnk
);
   import tbc_pkg::*;

   typedef enum logic [1:0] {HS_IDLE = 2'b01, HS_WAIT = 2'b10} tbc_hst_type;

   // Byte-lane merge for partial writes.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] be);
      for (int b = 0; b < 4; b++) begin
         old[b*8 +: 8] = be[b] ? nw[b*8 +: 8] : old[b*8 +: 8];
      end
      merge = old;
   endfunction

   tbc_hst_type st_r;                  // Command sequencer state.
   logic awready_r, wready_r, bvalid_r, arready_r, rvalid_r;
   logic [1:0] bresp_r, rresp_r;
   logic [31:0] rdata_r;
   logic [4:0] wa_r;                   // Captured write address.
   logic [31:0] wd_r;                  // Captured write data.
   logic [3:0] ws_r;                   // Captured byte enables.
   logic [31:0] cmd_r, addr_r, data_r, result_r;
   logic done_r, fault_r;
   logic cmd_valid_r;
   logic do_wr;                        // Both halves of a write are held.
   logic go;                           // Command register written while idle.

   assign do_wr = !awready_r && !wready_r && !bvalid_r;
   assign go = do_wr && wa_r == REG_CMD && st_r == HS_IDLE;

   // Write channels are taken independently; the response follows both.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_r <= 1'b1;
         wready_r <= 1'b1;
         bvalid_r <= 1'b0;
         bresp_r <= RESP_OKAY;
         wa_r <= '0;
         wd_r <= '0;
         ws_r <= '0;
      end else begin
         if (awvalid && awready_r) begin
            awready_r <= 1'b0;
            wa_r <= awaddr;
         end
         if (wvalid && wready_r) begin
            wready_r <= 1'b0;
            wd_r <= wdata;
            ws_r <= wstrb;
         end
         if (do_wr) begin
            bvalid_r <= 1'b1;
            // Unmapped or read-only offsets answer with an error.
            bresp_r <= (wa_r == REG_CMD || wa_r == REG_ADDR || wa_r == REG_DATA ||
                        wa_r == REG_STATUS) ? RESP_OKAY : RESP_SLVERR;
         end
         if (bvalid_r && bready) begin
            bvalid_r <= 1'b0;
            awready_r <= 1'b1;
            wready_r <= 1'b1;
         end
      end
   end

   // Command, address and operand registers; a command write while busy is dropped.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmd_r <= '0;
         addr_r <= '0;
         data_r <= '0;
      end else if (do_wr) begin
         if (go) begin
            cmd_r <= merge(cmd_r, wd_r, ws_r);
         end
         if (wa_r == REG_ADDR) begin
            addr_r <= merge(addr_r, wd_r, ws_r);
         end
         if (wa_r == REG_DATA) begin
            data_r <= merge(data_r, wd_r, ws_r);
         end
      end
   end

   // Sequencer: one command in flight, strobe for one cycle, wait for answer.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_r <= HS_IDLE;
         cmd_valid_r <= 1'b0;
      end else begin
         cmd_valid_r <= go;
         unique case (st_r)
            HS_IDLE: begin
               if (go) begin
                  st_r <= HS_WAIT;
               end
            end
            HS_WAIT: begin
               if (lnk.rsp_valid) begin
                  st_r <= HS_IDLE;
               end
            end
         endcase
      end
   end

   // Sticky done and fault; a new answer wins over a clear in the same cycle.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         done_r <= 1'b0;
         fault_r <= 1'b0;
         result_r <= '0;
      end else if (lnk.rsp_valid) begin
         done_r <= 1'b1;
         fault_r <= lnk.rsp_fault;
         result_r <= lnk.rsp_data;
      end else if (do_wr && wa_r == REG_STATUS && ws_r[0] && wd_r[ST_DONE_BIT]) begin
         done_r <= 1'b0;
         fault_r <= 1'b0;
      end
   end

   // Read channel answers one cycle after the address is taken.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_r <= 1'b1;
         rvalid_r <= 1'b0;
         rdata_r <= '0;
         rresp_r <= RESP_OKAY;
      end else if (arvalid && arready_r) begin
         arready_r <= 1'b0;
         rvalid_r <= 1'b1;
         rresp_r <= RESP_OKAY;
         unique case (araddr)
            REG_CMD: rdata_r <= cmd_r;
            REG_ADDR: rdata_r <= addr_r;
            REG_DATA: rdata_r <= data_r;
            REG_STATUS: rdata_r <= {29'h0, fault_r, done_r, st_r == HS_WAIT};
            REG_RESULT: rdata_r <= result_r;
            default: begin
               rdata_r <= '0;
               rresp_r <= RESP_SLVERR;
            end
         endcase
      end else if (rvalid_r && rready) begin
         rvalid_r <= 1'b0;
         arready_r <= 1'b1;
      end
   end

   assign awready = awready_r;
   assign wready = wready_r;
   assign bvalid = bvalid_r;
   assign bresp = bresp_r;
   assign arready = arready_r;
   assign rvalid = rvalid_r;
   assign rdata = rdata_r;
   assign rresp = rresp_r;
   assign lnk.cmd_valid = cmd_valid_r;
   assign lnk.cmd_op = tbc_op_type'(cmd_r[3:0]);
   assign lnk.cmd_kernel = cmd_r[CMD_KERNEL_BIT];
   assign lnk.cmd_pid = cmd_r[CMD_PID_LSB +: PID_W];
   assign lnk.cmd_addr = addr_r;
   assign lnk.cmd_data = data_r;
endmodule

//--- shared/tbc_if.sv
`timescale 1ns/10ps
// Link between the processor end and the translation buffer end.
interface tbc_if;
   logic cmd_valid;                    // One-cycle command strobe.
   tbc_pkg::tbc_op_type cmd_op;        // Command code.
   logic cmd_kernel;                   // High when issued in kernel mode.
   logic [31:0] cmd_addr;              // Virtual address of the command.
   logic [31:0] cmd_data;              // Register value or operand word.
   logic [7:0] cmd_pid;                // Current process number.
   logic rsp_valid;                    // One-cycle answer strobe.
   logic [31:0] rsp_data;              // Returned staging value.
   logic rsp_fault;                    // Privilege fault, command not executed.
   modport dev (input cmd_valid, cmd_op, cmd_kernel, cmd_addr, cmd_data, cmd_pid,
                output rsp_valid, rsp_data, rsp_fault);
   modport host (output cmd_valid, cmd_op, cmd_kernel, cmd_addr, cmd_data, cmd_pid,
                 input rsp_valid, rsp_data, rsp_fault);
endinterface

//--- shared/tbc_pkg.sv
package tbc_pkg;
   // Geometry of the translation buffer.
   localparam int SET_N = 4;
   localparam int ROW_W = 7;
   localparam int PID_W = 8;
   localparam int HPG_W = 9;
   localparam int PPN_W = 16;
   localparam int WORD_W = 32;
   // Virtual address fields: set selects, row, high page.
   localparam int VA_SEL_LSB = 23;
   localparam int VA_ROW_LSB = 16;
   localparam int VA_HPG_LSB = 23;
   // Tag staging word fields.
   localparam int TAG_VALID_BIT = 31;
   localparam int TAG_WR_BIT = 30;
   localparam int TAG_PID_LSB = 22;
   localparam int TAG_HPG_LSB = 13;
   localparam logic [31:0] TAG_MASK = 32'hFFFFE000;
   // Data staging word: page number in the upper half.
   localparam int DAT_PPN_LSB = 16;
   // Peripheral control word fields.
   localparam int CW_SETCTL_BIT = 0;
   localparam int CW_IOREAD_BIT = 1;
   localparam int CW_IOWRITE_BIT = 2;
   localparam int CW_KIND_W = 3;
   localparam int CW_REG_LSB = 8;
   localparam int MCREG_W = 8;
   // Reset values of the staging and control registers.
   localparam logic [31:0] STG_RST = 32'h00000000;
   // Host register offsets (byte addresses) and fields.
   localparam logic [4:0] REG_CMD = 5'h00;
   localparam logic [4:0] REG_ADDR = 5'h04;
   localparam logic [4:0] REG_DATA = 5'h08;
   localparam logic [4:0] REG_STATUS = 5'h0C;
   localparam logic [4:0] REG_RESULT = 5'h10;
   localparam int CMD_KERNEL_BIT = 8;
   localparam int CMD_PID_LSB = 16;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_DONE_BIT = 1;
   localparam int ST_FAULT_BIT = 2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Commands carried on the link.
   typedef enum logic [3:0] {
      OP_LOAD_TAG = 4'h0, OP_STORE_TAG = 4'h1, OP_TAG_READ = 4'h2, OP_TAG_WRITE = 4'h3,
      OP_LOAD_DATA = 4'h4, OP_STORE_DATA = 4'h5, OP_DATA_READ = 4'h6, OP_DATA_WRITE = 4'h7,
      OP_LOAD_CTL = 4'h8, OP_LAUNCH = 4'h9, OP_CTL_READ = 4'hA
   } tbc_op_type;
endpackage

//--- verif/tb_translation_buffer_access_and_periph_cmd.sv
`timescale 1ns/10ps
// Software traffic into the processor end, lookups into the buffer end.
module tb_translation_buffer_access_and_periph_cmd;
   import tbc_pkg::*;
   // Clock, reset and register bus.
   logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic awready, wready, bvalid, arready, rvalid;
   logic [4:0] awaddr, araddr;
   logic [3:0] ws;
   logic [31:0] wdata, rdata;
   logic [1:0] bresp, rresp, rs;
   // Lookup and memory controller sides.
   logic lk_valid, lk_store, lk_user, lk_done, lk_hit, lk_wp_fault, mc_valid;
   logic [31:0] lk_vaddr, mc_word;
   logic [7:0] lk_pid, mc_reg, pid;
   logic [15:0] lk_ppn;
   logic [2:0] mc_kind;
   // Bench state.
   logic [31:0] failures, n_tests, mc_n, res, st, tg, tg2, dv;
   logic [6:0] row;
   int i;
   tbc_if lnk();
   tbc_host u_tbc_host (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(ws),
      .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
      .lnk(lnk));
   tbc_dev u_tbc_dev (.aclk(aclk), .aresetn(aresetn), .lnk(lnk), .lk_valid(lk_valid),
      .lk_vaddr(lk_vaddr), .lk_pid(lk_pid), .lk_store(lk_store), .lk_user(lk_user),
      .lk_done(lk_done), .lk_hit(lk_hit), .lk_ppn(lk_ppn), .lk_wp_fault(lk_wp_fault),
      .mc_valid(mc_valid), .mc_kind(mc_kind), .mc_word(mc_word), .mc_reg(mc_reg));
   tbc_link_properties u_tbc_link_properties (.aclk(aclk), .aresetn(aresetn),
      .cmd_valid(lnk.cmd_valid), .cmd_op(lnk.cmd_op), .cmd_kernel(lnk.cmd_kernel),
      .cmd_addr(lnk.cmd_addr), .cmd_data(lnk.cmd_data), .cmd_pid(lnk.cmd_pid),
      .rsp_valid(lnk.rsp_valid), .rsp_data(lnk.rsp_data), .rsp_fault(lnk.rsp_fault));
   // Free-running 200 MHz clock.
   initial begin
      aclk = 1'b0;
      forever #2.5 aclk = ~aclk;
   end
   // Count launches so that silent commands can be told apart.
   always @(posedge aclk) begin
      if (!aresetn) begin
         mc_n <= 32'h0;
      end else if (mc_valid === 1'b1) begin
         mc_n <= mc_n + 32'h1;
      end
   end
   task automatic end_of_test();
      if (failures == 0 && n_tests > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests = n_tests + 32'h1;
      if (got !== exp) begin
         failures = failures + 32'h1;
         $display("MISMATCH %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic tmo();
      failures = failures + 32'h1;
      $display("MISMATCH %0t wait ran out", $time);
      end_of_test();
   endtask
   // Each channel is released at the edge where its ready is seen.
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) begin
            rs = bresp;
            bready <= 1'b0;
            n = 99;
         end
      end
      if (n == 40) tmo();
   endtask
   task automatic rd(input logic [4:0] a, output logic [31:0] d);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge aclk);
         if (arready) arvalid <= 1'b0;
         if (rvalid) begin
            d = rdata;
            rs = rresp;
            rready <= 1'b0;
            n = 99;
         end
      end
      if (n == 40) tmo();
   endtask
   // One link command: status and result are kept, then done is cleared.
   task automatic cmd(input tbc_op_type op, input logic k, input logic [31:0] a,
      input logic [31:0] d);
      int n;
      wr(REG_ADDR, a);
      wr(REG_DATA, d);
      wr(REG_CMD, {8'h00, pid, 7'h00, k, 4'h0, op});
      for (n = 0; n < 20; n++) begin
         rd(REG_STATUS, st);
         if (st[ST_DONE_BIT] === 1'b1) n = 99;
      end
      if (n == 20) tmo();
      rd(REG_RESULT, res);
      wr(REG_STATUS, 32'h00000002);
   endtask
   // A store lookup; expected is {page, 13 zeros, done, hit, protect fault}.
   task automatic look(input logic [31:0] va, input logic [7:0] p, input logic u,
      input logic [31:0] e);
      @(posedge aclk);
      lk_vaddr <= va;
      lk_pid <= p;
      lk_user <= u;
      lk_store <= 1'b1;
      lk_valid <= 1'b1;
      @(posedge aclk);
      lk_valid <= 1'b0;
      #1;
      chk({lk_ppn, 13'h0000, lk_done, lk_hit, lk_wp_fault}, e);
   endtask
   initial begin
      failures = 32'h0;
      n_tests = 32'h0;
      aresetn = 1'b0;
      ws = 4'hF;
      {awvalid, wvalid, bready, arvalid, rready, lk_valid, lk_store, lk_user} = 8'h00;
      {awaddr, araddr, wdata, lk_vaddr, lk_pid} = 82'h0;
      pid = 8'h35;
      row = 7'h15;
      dv = 32'hBEEF1234;
      tg = {2'b10, pid, 9'h0AB, 13'h0000};
      tg2 = {2'b11, pid, 9'h0CD, 13'h0000};
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      // Reset values and refused accesses.
      rd(REG_RESULT, res);
      chk(res, STG_RST);
      rd(5'h14, res);
      chk({res[29:0], rs}, {30'h0, RESP_SLVERR});
      wr(REG_RESULT, 32'hFFFFFFFF);
      chk({30'h0, rs}, {30'h0, RESP_SLVERR});
      ws <= 4'h2;
      wr(REG_DATA, 32'hFFFFFFFF);
      ws <= 4'hF;
      rd(REG_DATA, res);
      chk(res, 32'h0000FF00);
      cmd(OP_STORE_TAG, 1'b1, 0, 0);
      chk(res, STG_RST);
      // Staging loads, a refused user load, and read-back.
      cmd(OP_LOAD_TAG, 1'b1, 0, tg);
      cmd(OP_LOAD_DATA, 1'b1, 0, dv);
      cmd(OP_LOAD_TAG, 1'b0, 0, 32'h12345678);
      chk({31'h0, st[ST_FAULT_BIT]}, 32'h1);
      cmd(OP_STORE_TAG, 1'b1, 0, 0);
      chk(res, tg);
      cmd(OP_STORE_DATA, 1'b1, 0, 0);
      chk(res, dv);
      // Fill a whole row, overwrite one set, then read each set alone.
      cmd(OP_TAG_WRITE, 1'b1, {5'h00, 4'hF, row, 16'h0000}, 0);
      cmd(OP_DATA_WRITE, 1'b1, {5'h00, 4'hF, row, 16'h0000}, 0);
      cmd(OP_LOAD_TAG, 1'b1, 0, tg2);
      cmd(OP_TAG_WRITE, 1'b1, {5'h00, 4'h4, row, 16'h0000}, 0);
      for (i = 0; i < 4; i++) begin
         cmd(OP_TAG_READ, 1'b1, {5'h00, 4'h1 << i, row, 16'h0000}, 0);
         cmd(OP_STORE_TAG, 1'b1, 0, 0);
         chk(res, (i == 2) ? tg2 : tg);
         cmd(OP_DATA_READ, 1'b1, {5'h00, 4'h1 << i, row, 16'h0000}, 0);
         cmd(OP_STORE_DATA, 1'b1, 0, 0);
         chk(res, {dv[31:16], 16'h0000});
      end
      // Lookups against that row.
      look({9'h0AB, row, 16'h0000}, pid, 1'b1, {dv[31:16], 16'h0007});
      look({9'h0AB, row, 16'h0000}, pid, 1'b0, {dv[31:16], 16'h0006});
      look({9'h0CD, row, 16'h0000}, pid, 1'b1, {dv[31:16], 16'h0006});
      look({9'h0AB, row ^ 7'h01, 16'h0000}, pid ^ 8'h01, 1'b1, 32'h00000004);
      cmd(OP_LOAD_TAG, 1'b1, 0, {1'b0, tg[30:0]});
      cmd(OP_TAG_WRITE, 1'b1, {5'h00, 4'hF, row, 16'h0000}, 0);
      look({9'h0AB, row, 16'h0000}, pid, 1'b0, 32'h00000004);
      // Each operation kind; the register number lags by one launch, except after the control read at i == 2.
      for (i = 0; i < 3; i++) begin
         cmd(OP_LOAD_CTL, 1'b1, 0, {16'h0000, 8'h05 + 8'(2 * i), 5'h00, 3'h4 >> i});
         chk(mc_n, i);
         if (i == 2) cmd(OP_CTL_READ, 1'b1, 0, 0);
         cmd(OP_LAUNCH, 1'b1, 0, 32'h00001000 + 8 * i);
         chk(mc_n, i + 1);
         chk(mc_word, 32'h00001000 + 8 * i);
         chk({mc_reg, mc_kind}, {i == 0 ? 8'h00 : (i == 1 ? 8'h05 : 8'h09), 3'h4 >> i});
      end
      cmd(OP_LAUNCH, 1'b0, 0, 32'h00002000);
      chk(mc_n, 32'h3);
      end_of_test();
   end
endmodule

//--- verif/tbc_link_properties.sv
`timescale 1ns/10ps
// Watches the command link between the processor end and the buffer end.
module tbc_link_properties (
   // Clock and reset.
   input wire logic aclk,
   input wire logic aresetn,
   // Commands.
   input wire logic cmd_valid,
   input wire tbc_pkg::tbc_op_type cmd_op,
   input wire logic cmd_kernel,
   input wire logic [31:0] cmd_addr,
   input wire logic [31:0] cmd_data,
   input wire logic [7:0] cmd_pid,
   // Answers.
   input wire logic rsp_valid,
   input wire logic [31:0] rsp_data,
   input wire logic rsp_fault
);
   import tbc_pkg::*;
   logic [31:0] tag_m; // Last tag loaded in kernel mode.
   logic [31:0] dat_m; // Last data word loaded in kernel mode.
   logic tag_ok; // Tag staging still equals tag_m.
   logic dat_ok; // Data staging still equals dat_m.
   wire kcmd = cmd_valid && cmd_kernel;
   // A buffer read refills staging from storage, so prediction stops there.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         tag_m <= STG_RST;
         tag_ok <= 1'b1;
      end else if (kcmd && cmd_op == OP_LOAD_TAG) begin
         tag_m <= cmd_data;
         tag_ok <= 1'b1;
      end else if (kcmd && cmd_op == OP_TAG_READ) begin
         tag_ok <= 1'b0;
      end
   end
   // Same tracking for the data staging word.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         dat_m <= STG_RST;
         dat_ok <= 1'b1;
      end else if (kcmd && cmd_op == OP_LOAD_DATA) begin
         dat_m <= cmd_data;
         dat_ok <= 1'b1;
      end else if (kcmd && cmd_op == OP_DATA_READ) begin
         dat_ok <= 1'b0;
      end
   end
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   property p_rsp_next;
      cmd_valid |=> rsp_valid;
   endproperty
   a_rsp_next: assert property (p_rsp_next) else $error("command not answered");
   property p_rsp_cause;
      rsp_valid |-> $past(cmd_valid);
   endproperty
   a_rsp_cause: assert property (p_rsp_cause) else $error("answer without command");
   property p_user_flt;
      cmd_valid && !cmd_kernel |=> rsp_fault;
   endproperty
   a_user_flt: assert property (p_user_flt) else $error("user command ran");
   property p_kern_run;
      kcmd |=> !rsp_fault;
   endproperty
   a_kern_run: assert property (p_kern_run) else $error("kernel command faulted");
   property p_tag_back;
      kcmd && cmd_op == OP_STORE_TAG && tag_ok |=> rsp_data == tag_m;
   endproperty
   a_tag_back: assert property (p_tag_back) else $error("tag staging wrong");
   property p_dat_back;
      kcmd && cmd_op == OP_STORE_DATA && dat_ok |=> rsp_data == dat_m;
   endproperty
   a_dat_back: assert property (p_dat_back) else $error("data staging wrong");
   property p_ctl_quiet;
      kcmd && (cmd_op == OP_LOAD_CTL || cmd_op == OP_LAUNCH) |=> rsp_data == 32'h00000000;
   endproperty
   a_ctl_quiet: assert property (p_ctl_quiet) else $error("control word read back");
   property p_one_cmd;
      cmd_valid |=> !cmd_valid;
   endproperty
   a_one_cmd: assert property (p_one_cmd) else $error("command strobe too long");
   c_launch: cover property (kcmd && cmd_op == OP_LAUNCH);
   c_user: cover property (cmd_valid && !cmd_kernel);
   c_twrite: cover property (kcmd && cmd_op == OP_TAG_WRITE);
endmodule
